// ===== rate_data_ready_status.sv
// rate_data_ready_status.sv: per-axis ready/overwrite flags and the status read mux
// assumes sample strobes and register requests come from logic on clk
// Functional notes
// - All status bits clear when the mode goes from standby or ready into active.
// - Bit 7 sets when a full x, y, z set lands before the previous set was fully read.
// - Bit 7 clears only once the high bytes of all axes sampled since the last full read have been read.
// - Bit 6 sets when a new z sample lands while the old one is still unread.
// - Bit 5 sets when a new y sample lands while the old one is still unread.
// - Bit 4 sets when a new x sample lands while the old one is still unread.
// - Each axis overwrite bit clears when that axis high byte is read.
// - Bit 3 sets whenever any axis has a new sample.
// - Bit 3 clears only after the high bytes of all axes sampled since the last full read have been read.
// - Bit 2 sets on each completed z sample.
// - Bit 2 clears on a read of the z high byte, regardless of other axes.
// - Bit 1 sets on each y sample and clears on a read of the y high byte.
// - Bit 0 sets on each x sample and clears on a read of the x high byte.
// - Address 0x00 mirrors this register while the fifo is off, else the fifo status.
// - With fifo mode 00 the output registers update per sample, driving these flags.
`timescale 1ns/10ps
`default_nettype none
`include "rate_status_defs.svh"

module rate_data_ready_status (
   // clock, reset, enable
   input  wire logic                         clk,
   input  wire logic                         nrst,
   input  wire logic                         clk_en,
   // core state
   input  wire rate_status_pkg::op_mode_e    op_mode,
   input  wire logic [1:0]                   fifo_mode,
   input  wire logic [7:0]                   fifo_status,
   input  wire rate_status_pkg::axis_strobe_s sample_done,
   // register access
   input  wire rate_status_pkg::reg_req_s    reg_req,
   output logic [7:0]                        reg_rdata,
   output logic                              reg_rvalid,
   output logic [7:0]                        sample_ready_status
);
   import rate_status_pkg::*;

   // ****************************************************************
   // reset release
   // ****************************************************************
   logic [1:0] rst_sync;
   logic       rst_n;

   // two-stage release so no flop leaves reset on a ragged edge
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rst_sync <= 2'h0;
      end else begin
         rst_sync <= {rst_sync[0], 1'b1};
      end
   end
   assign rst_n = rst_sync[1];

   // ****************************************************************
   // decode
   // ****************************************************************
   function automatic logic rd_hit(input reg_req_s r, input logic [7:0] a);
      rd_hit = r.rd && (r.addr == a);
   endfunction

   op_mode_e     prev_mode;
   logic         enter_active;
   axis_strobe_s hi_read;
   axis_strobe_s new_smp;
   logic [2:0]   set_read;    // high bytes read since each axis was last sampled
   logic [2:0]   set_fresh;   // axes sampled since last full set
   logic         all_read;
   logic         full_set;
   logic         x_dr;
   logic         y_dr;
   logic         z_dr;
   logic         any_dr;
   logic         x_ow;
   logic         y_ow;
   logic         z_ow;
   logic         all_ow;
   logic [2:0]   read_vec;        // high-byte reads, z y x
   logic [2:0]   smp_vec;         // accepted samples, z y x
   logic [2:0]   next_set_read;
   logic [2:0]   next_set_fresh;
   logic [7:0]   flags;           // status byte at its bit positions

   assign hi_read.x = rd_hit(reg_req, `ADDR_OUT_X_HI);
   assign hi_read.y = rd_hit(reg_req, `ADDR_OUT_Y_HI);
   assign hi_read.z = rd_hit(reg_req, `ADDR_OUT_Z_HI);
   assign new_smp = (fifo_mode == `FIFO_MODE_OFF) ? sample_done : 3'h0;
   // flat z y x views of the read and sample strobes
   assign read_vec = {hi_read.z, hi_read.y, hi_read.x};
   assign smp_vec  = {new_smp.z, new_smp.y, new_smp.x};
   // read tracking including this cycle's read
   assign all_read = &(set_read | read_vec);
   assign full_set = &(set_fresh | smp_vec);
   assign enter_active = (op_mode == mode_active)
                         && ((prev_mode == mode_standby) || (prev_mode == mode_ready));

   // ****************************************************************
   // set tracking
   // ****************************************************************
   // a new sample on an axis re-arms its pending read; a read with no
   // sample closes the set once every outstanding axis has been read
   always_comb begin
      next_set_read  = (set_read | read_vec) & ~smp_vec;
      next_set_fresh = set_fresh | smp_vec;
      if (all_read && !(|new_smp)) begin
         next_set_read = 3'h7;
      end
      // a full set restarts the count of freshly sampled axes
      if (full_set) begin
         next_set_fresh = 3'h0;
      end
   end

   // ****************************************************************
   // status byte packing
   // ****************************************************************
   // one place fixes the bit order for the output, the register and the mirror
   always_comb begin
      flags              = `RST_SAMPLE_READY;
      flags[`BIT_ALL_OW] = all_ow;
      flags[`BIT_Z_OW]   = z_ow;
      flags[`BIT_Y_OW]   = y_ow;
      flags[`BIT_X_OW]   = x_ow;
      flags[`BIT_ANY_DR] = any_dr;
      flags[`BIT_Z_DR]   = z_dr;
      flags[`BIT_Y_DR]   = y_dr;
      flags[`BIT_X_DR]   = x_dr;
   end

   // ****************************************************************
   // mode tracking
   // ****************************************************************
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prev_mode <= mode_standby;
      end else if (clk_en) begin
         prev_mode <= op_mode;
      end
   end

   // ****************************************************************
   // per-axis ready and overwrite flags
   // ****************************************************************
   // a ready set wins over a same-cycle read so no sample goes unreported; a same-cycle read still clears the axis overwrite flag
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         {z_dr, y_dr, x_dr} <= 3'h0;
         {z_ow, y_ow, x_ow} <= 3'h0;
      end else if (clk_en) begin
         if (enter_active) begin
            {z_dr, y_dr, x_dr} <= 3'h0;
            {z_ow, y_ow, x_ow} <= 3'h0;
         end else begin
            z_dr <= new_smp.z | (z_dr & ~hi_read.z);
            y_dr <= new_smp.y | (y_dr & ~hi_read.y);
            x_dr <= new_smp.x | (x_dr & ~hi_read.x);
            z_ow <= (new_smp.z & z_dr & ~hi_read.z) | (z_ow & ~hi_read.z);
            y_ow <= (new_smp.y & y_dr & ~hi_read.y) | (y_ow & ~hi_read.y);
            x_ow <= (new_smp.x & x_dr & ~hi_read.x) | (x_ow & ~hi_read.x);
         end
      end
   end

   // ****************************************************************
   // combined flags and set tracking
   // ****************************************************************
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         set_read  <= 3'h7;
         set_fresh <= 3'h0;
         any_dr    <= 1'b0;
         all_ow    <= 1'b0;
      end else if (clk_en) begin
         if (enter_active) begin
            set_read  <= 3'h7;
            set_fresh <= 3'h0;
            any_dr    <= 1'b0;
            all_ow    <= 1'b0;
         end else begin
            // set tracking from the next-value logic above
            set_read  <= next_set_read;
            set_fresh <= next_set_fresh;
            any_dr <= (|new_smp) | (any_dr & ~all_read);
            all_ow <= (full_set & ~all_read & any_dr) | (all_ow & ~all_read);
         end
      end
   end

   // ****************************************************************
   // read port
   // ****************************************************************
   // writes never reach the flags; only reads are served
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata           <= 8'h00;
         reg_rvalid          <= 1'b0;
         sample_ready_status <= `RST_SAMPLE_READY;
      end else if (clk_en) begin
         sample_ready_status <= flags;
         reg_rvalid          <= reg_req.rd;
         if (rd_hit(reg_req, `ADDR_SAMPLE_READY)) begin
            reg_rdata <= flags;
         end else if (rd_hit(reg_req, `ADDR_MIRROR_STATUS)) begin
            reg_rdata <= (fifo_mode == `FIFO_MODE_OFF) ? flags : fifo_status;
         end else if (reg_req.rd) begin
            reg_rdata <= 8'h00;   // other registers live elsewhere
         end
      end
   end

endmodule // rate_data_ready_status
`default_nettype wire

// ===== rate_status_defs.svh
// rate_status_defs.svh: offsets, field positions, reset values for the data-ready status block
// assumes inclusion by bare name from the package and the design file
`ifndef RATE_STATUS_DEFS_SVH
`define RATE_STATUS_DEFS_SVH

// ****************************************************************
// register offsets (8-bit register address space)
// ****************************************************************
`define ADDR_MIRROR_STATUS   8'h00
`define ADDR_OUT_X_HI        8'h01
`define ADDR_OUT_Y_HI        8'h03
`define ADDR_OUT_Z_HI        8'h05
`define ADDR_SAMPLE_READY    8'h07
`define ADDR_FIFO_STATUS     8'h08

// ****************************************************************
// field positions and reset values
// ****************************************************************
`define BIT_ALL_OW           7
`define BIT_Z_OW             6
`define BIT_Y_OW             5
`define BIT_X_OW             4
`define BIT_ANY_DR           3
`define BIT_Z_DR             2
`define BIT_Y_DR             1
`define BIT_X_DR             0
`define RST_SAMPLE_READY     8'h00
`define FIFO_MODE_OFF        2'h0

`endif

// ===== rate_status_pkg.sv
// rate_status_pkg.sv: types shared by the data-ready status block
// assumes the defs header sits in the same folder
`include "rate_status_defs.svh"

package rate_status_pkg;

   // operating modes of the sensor core
   typedef enum logic [2:0] {
      mode_standby = 3'b001,
      mode_ready   = 3'b010,
      mode_active  = 3'b100
   } op_mode_e;

   // one strobe per axis, z y x order
   typedef struct packed {
      logic z;
      logic y;
      logic x;
   } axis_strobe_s;

   // register read or write request from the serial front end
   typedef struct packed {
      logic       rd;
      logic       wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_s;

endpackage

// ===== rate_status_properties.sv
// rate_status_properties.sv: timing checks for the data-ready status block
// assumes a bind onto rate_data_ready_status, one clock domain
`timescale 1ns/10ps
`default_nettype none
module rate_status_properties (
   // clock, reset, enable
   input wire logic                          clk,
   input wire logic                          nrst,
   input wire logic                          clk_en,
   // core state
   input wire rate_status_pkg::op_mode_e     op_mode,
   input wire logic [1:0]                    fifo_mode,
   input wire logic [7:0]                    fifo_status,
   input wire rate_status_pkg::axis_strobe_s sample_done,
   // register side
   input wire rate_status_pkg::reg_req_s     reg_req,
   input wire logic [7:0]                    reg_rdata,
   input wire logic [7:0]                    sample_ready_status,
   input wire logic                          reg_rvalid
);
   import rate_status_pkg::*;
   logic       rd;
   logic [7:0] a, s;
   // short aliases; the status output lags the flags by one edge
   assign rd = clk_en && reg_req.rd;
   assign a = reg_req.addr;
   assign s = sample_ready_status;
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   x_ready_set_a: assert property (clk_en && sample_done.x && fifo_mode == 2'h0
      && $stable(op_mode) |-> ##2 s[0])
      else $error("x ready bit not set");
   z_ready_set_a: assert property (clk_en && sample_done.z && fifo_mode == 2'h0
      && $stable(op_mode) |-> ##2 s[2])
      else $error("z ready bit not set");
   y_ready_clear_a: assert property (rd && a == 8'h03 && !sample_done.y |-> ##2 !s[1])
      else $error("y ready bit not cleared");
   x_overwrite_a: assert property ((clk_en && sample_done.x && !(rd && a == 8'h01) && fifo_mode == 2'h0
      && $stable(op_mode)) ##1 s[0] |-> ##1 s[4])
      else $error("x overwrite bit not set");
   any_ready_a: assert property (s[2:0] != 3'h0 |-> s[3])
      else $error("combined ready bit low while an axis is ready");
   read_pulse_a: assert property (clk_en |=> reg_rvalid == $past(rd))
      else $error("read valid pulse wrong");
   status_read_a: assert property (rd && a == 8'h07 |=> reg_rdata == s)
      else $error("status read data wrong");
   mirror_read_a: assert property (rd && a == 8'h00
      |=> reg_rdata == ($past(fifo_mode) == 2'h0 ? s : $past(fifo_status)))
      else $error("mirror read data wrong");
   unmapped_zero_a: assert property (rd && !(a inside {8'h00, 8'h07}) |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   mode_clear_a: assert property (op_mode == mode_active && $past(op_mode) != mode_active |-> ##2 s == 8'h00)
      else $error("status not cleared on entry to active");
   write_ignored_a: assert property (clk_en && reg_req.wr && !reg_req.rd && sample_done == 3'h0
      && $stable(op_mode) |-> ##2 $stable(s))
      else $error("write changed the status");
   cover property (s[7]);
   cover property (rd && a == 8'h00 && fifo_mode != 2'h0);
   cover property (op_mode == mode_active && $past(op_mode) == mode_ready);
endmodule // rate_status_properties
`default_nettype wire

// ===== rate_host_model.sv
// rate_host_model.sv: host side issuing register accesses
// assumes the block answers one edge after the strobe
`timescale 1ns/10ps
`default_nettype none
module rate_host_model (
   input wire logic                      clk,
   input wire logic [7:0]                reg_rdata,
   output var rate_status_pkg::reg_req_s reg_req
);
   initial reg_req = '0;
   // strobe held across one rising edge; answer taken at the next falling edge
   task automatic access(input logic w, input logic [7:0] ad, wd, output logic [7:0] d);
      @(negedge clk);
      reg_req = {~w, w, ad, wd};
      @(negedge clk);
      reg_req = '0;
      d = reg_rdata;
   endtask
endmodule // rate_host_model
`default_nettype wire

// ===== tb_top.sv
// tb_top.sv: directed test of the data-ready status block
// assumes package, design and host model compiled first
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   import rate_status_pkg::*;
   logic         clk, nrst, clk_en, reg_rvalid;
   logic [1:0]   fifo_mode;
   logic [7:0]   fifo_status, reg_rdata, sample_ready_status, d;
   op_mode_e     op_mode;
   axis_strobe_s sample_done;
   reg_req_s     reg_req;
   int           fails = 0, cmp_count = 0, cycles = 0;
   rate_data_ready_status u_rate_data_ready_status (.clk(clk), .nrst(nrst), .clk_en(clk_en), .op_mode(op_mode),
      .fifo_mode(fifo_mode), .fifo_status(fifo_status), .sample_done(sample_done), .reg_req(reg_req),
      .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .sample_ready_status(sample_ready_status));
   rate_host_model u_rate_host_model (.clk(clk), .reg_rdata(reg_rdata), .reg_req(reg_req));
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   // hang guard, far above the hundred or fewer cycles the tests need
   always @(posedge clk) begin
      cycles++;
      if (cycles == 2000) begin
         fails++;
         report_and_stop();
      end
   end
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic chk(string n, logic [7:0] seen, exp);
      cmp_count++;
      if (seen !== exp) begin
         fails++;
         $display("mismatch %s expected %h seen %h", n, exp, seen);
      end
   endtask
   task automatic rd(logic [7:0] ad, exp, string n);
      u_rate_host_model.access(1'b0, ad, 8'h00, d);
      chk(n, d, exp);
   endtask
   task automatic pulse(axis_strobe_s st);
      @(negedge clk);
      sample_done = st;
      @(negedge clk);
      sample_done = '0;
   endtask
   // main sequence; all inputs change on falling edges
   initial begin
      nrst = 1'b0;
      clk_en = 1'b1;
      op_mode = mode_standby;
      fifo_mode = 2'h0;
      fifo_status = 8'ha5;
      sample_done = '0;
      repeat (8) @(negedge clk);
      nrst = 1'b1;
      repeat (3) @(negedge clk);
      chk("status reset", sample_ready_status, 8'h00);
      op_mode = mode_active;
      repeat (3) @(negedge clk);
      pulse(3'h7);
      rd(8'h00, 8'h0f, "mirror");
      rd(8'h01, 8'h00, "x high");
      rd(8'h07, 8'h0e, "after x");
      rd(8'h05, 8'h00, "z high");
      rd(8'h07, 8'h0a, "after z");
      rd(8'h03, 8'h00, "y high");
      rd(8'h07, 8'h00, "after y");
      $display("test ready done");
      pulse(3'h7);
      pulse(3'h7);
      rd(8'h07, 8'hff, "overwrite");
      rd(8'h05, 8'h00, "z high");
      rd(8'h07, 8'hbb, "ow after z");
      rd(8'h03, 8'h00, "y high");
      rd(8'h01, 8'h00, "x high");
      rd(8'h07, 8'h00, "ow after all");
      $display("test overwrite done");
      pulse(3'h1);
      u_rate_host_model.access(1'b1, 8'h07, 8'hff, d);
      rd(8'h07, 8'h09, "after write");
      fifo_mode = 2'h1;
      rd(8'h00, 8'ha5, "fifo mirror");
      pulse(3'h2);
      rd(8'h07, 8'h09, "fifo sample");
      fifo_mode = 2'h0;
      rd(8'h20, 8'h00, "unmapped");
      // a strobe while the enable is low must leave every flag alone
      clk_en = 1'b0;
      pulse(3'h2);
      clk_en = 1'b1;
      rd(8'h07, 8'h09, "frozen");
      // sample and high-byte read in one cycle: the ready flag stays set
      fork
         pulse(3'h1);
         rd(8'h01, 8'h00, "x high with sample");
      join
      rd(8'h07, 8'h09, "set wins");
      $display("test access done");
      // entry to active from each idle mode
      for (int i = 0; i < 2; i++) begin
         pulse(3'h6);
         op_mode = i ? mode_standby : mode_ready;
         repeat (2) @(negedge clk);
         op_mode = mode_active;
         repeat (3) @(negedge clk);
         rd(8'h07, 8'h00, "mode entry");
      end
      $display("test mode done");
      report_and_stop();
   end
endmodule // tb_top
bind rate_data_ready_status rate_status_properties u_rate_status_properties (.clk(clk), .nrst(nrst),
   .clk_en(clk_en), .op_mode(op_mode), .fifo_mode(fifo_mode), .fifo_status(fifo_status),
   .sample_done(sample_done), .reg_req(reg_req), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
   .sample_ready_status(sample_ready_status));
`default_nettype wire
